// ==== hw/lsfs_pkg.sv ====
// Constants, timing counts and state type for the LED boost fault supervisor
package lsfs_pkg;
   // ----------------------------------------------------------------
   // Clock and geometry
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CODE_W = 8;
   localparam int unsigned TIMER_W = 27;
   localparam int unsigned SYNC_W = 4 + 4 * NUM_CH + 2;
   // ----------------------------------------------------------------
   // Adaptive target codes
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
   localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
   // Scale 0.88 of full range, 224.4 truncated
   localparam logic [CODE_W-1:0] CODE_INIT = 8'hE0;
   // ----------------------------------------------------------------
   // Times in their own units and derived cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned RECOVERY_MS = 100;
   localparam int unsigned SOFT_START_MS = 65;
   localparam int unsigned BOOST_START_MS = 50;
   localparam int unsigned FB_OVP_MS = 560;
   localparam int unsigned STANDBY_US = 50;
   localparam int unsigned PULSE_MIN_US = 2;
   localparam int unsigned PULSE_MAX_US = 20;
   localparam int unsigned STEP_US = 1;
   localparam int unsigned RECOVERY_CYC = (CLK_HZ / 1000) * RECOVERY_MS;
   localparam int unsigned SOFT_START_CYC = (CLK_HZ / 1000) * SOFT_START_MS;
   localparam int unsigned BOOST_START_CYC = (CLK_HZ / 1000) * BOOST_START_MS;
   localparam int unsigned FB_OVP_CYC = (CLK_HZ / 1000) * FB_OVP_MS;
   localparam int unsigned STANDBY_CYC = (CLK_HZ / 1000000) * STANDBY_US;
   // Least time rounds up, longest time rounds down
   localparam int unsigned PULSE_MIN_CYC = (CLK_HZ * PULSE_MIN_US + 999999) / 1000000;
   localparam int unsigned PULSE_MAX_CYC = (CLK_HZ / 1000000) * PULSE_MAX_US;
   localparam int unsigned STEP_CYC = (CLK_HZ / 1000000) * STEP_US;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_SOFT_START,
      ST_BOOST_START,
      ST_NORMAL,
      ST_RECOVERY
   } lsfs_state_e;
endpackage

// ==== hw/lsfs_sync_if.sv ====
// Bundle of raw comparator, enable and PWM levels and their synchronised copies
`timescale 1ns/10ps
`default_nettype none
interface lsfs_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface
`default_nettype wire

// ==== hw/lsfs_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module lsfs_sync
(
   input wire logic mclk,
   input wire logic srst,
   lsfs_sync_if.dst bus
);
   logic [$bits(bus.raw)-1:0] stage1;
   logic [$bits(bus.raw)-1:0] stage2;
   logic [$bits(bus.raw)-1:0] next_stage1;
   logic [$bits(bus.raw)-1:0] next_stage2;

   always_comb
   begin
      next_stage1 = bus.raw;
      next_stage2 = stage1;
      if (srst)
      begin
         next_stage1 = '0;
         next_stage2 = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
   end

   assign bus.synced = stage2;
endmodule // lsfs_sync
`default_nettype wire

// ==== hw/lsfs_supervisor.sv ====
// Start-up sequencer, adaptive boost target, fault supervisor and PWM gating
//
// Notes on behaviour
// RULE_01: Raise target when any live channel reads low.
// RULE_02: Lower target when all live channels sit high.
// RULE_03: Hold target while lowest channel is regulated.
// RULE_04: Target spans zero to full; starts at 0.88.
// RULE_05: Grounded sinks found at start-up, then excluded.
// RULE_06: Sink gating mirrors the brightness PWM input.
// RULE_07: Supply undervoltage shuts down, enters recovery.
// RULE_08: Recovery lasts 100 ms, then restart.
// RULE_09: Supply overvoltage shuts down, enters recovery.
// RULE_10: Feedback overvoltage in normal enters recovery.
// RULE_11: Switch-node overvoltage shuts down, enters recovery.
// RULE_12: Each channel has low, mid, high comparators.
// RULE_13: Any LED fault pulls fault pin low.
// RULE_14: Open string: target at max, channel low.
// RULE_15: Open channel disabled; others keep running.
// RULE_16: Short string: high while another regulates.
// RULE_17: Short enable pulse clears LED faults.
// RULE_18: Feedback overvoltage must persist beyond 560 ms.
// RULE_19: Reaching normal after recovery releases fault pin.
// RULE_20: Comparator inputs synchronised before use.
// RULE_21: Recovery keeps everything off, timer not restarted.
`timescale 1ns/10ps
`default_nettype none
module lsfs_supervisor #(
   parameter int unsigned RECOVERY_CYC = lsfs_pkg::RECOVERY_CYC,
   parameter int unsigned SOFT_START_CYC = lsfs_pkg::SOFT_START_CYC,
   parameter int unsigned BOOST_START_CYC = lsfs_pkg::BOOST_START_CYC,
   parameter int unsigned FB_OVP_CYC = lsfs_pkg::FB_OVP_CYC,
   parameter int unsigned STANDBY_CYC = lsfs_pkg::STANDBY_CYC,
   parameter int unsigned STEP_CYC = lsfs_pkg::STEP_CYC
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic supplyUnderV,
   input wire logic supplyOverV,
   input wire logic feedbackOverV,
   input wire logic switchNodeOverV,
   input wire logic [lsfs_pkg::NUM_CH-1:0] chanBelowLow,
   input wire logic [lsfs_pkg::NUM_CH-1:0] chanAboveMid,
   input wire logic [lsfs_pkg::NUM_CH-1:0] chanAboveHigh,
   input wire logic [lsfs_pkg::NUM_CH-1:0] chanGrounded,
   input wire logic enableInput,
   input wire logic pwmInput,
   output logic boostEnable,
   output logic powerLineEnable,
   output logic [lsfs_pkg::NUM_CH-1:0] ledSinkChannel,
   output logic [lsfs_pkg::CODE_W-1:0] targetCode,
   output logic faultPinOut,
   output logic faultPinOe,
   output logic [lsfs_pkg::NUM_CH-1:0] openStringFault,
   output logic [lsfs_pkg::NUM_CH-1:0] shortedStringFault,
   output logic [lsfs_pkg::NUM_CH-1:0] groundedChannel,
   output logic [2:0] stateCode
);
   localparam int unsigned N = lsfs_pkg::NUM_CH;
   localparam int unsigned TW = lsfs_pkg::TIMER_W;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   lsfs_sync_if #(.W(lsfs_pkg::SYNC_W)) syncBus ();
   assign syncBus.raw = {supplyUnderV, supplyOverV, feedbackOverV, switchNodeOverV,
                         chanBelowLow, chanAboveMid, chanAboveHigh, chanGrounded,
                         enableInput, pwmInput};
   lsfs_sync uSync (
      .mclk(mclk),
      .srst(srst),
      .bus(syncBus.dst)
   ); // RULE_20

   logic uvS, ovS, fbS, swS, enS, pwmS;
   logic [N-1:0] lowS, midS, highS, gndS;
   assign {uvS, ovS, fbS, swS, lowS, midS, highS, gndS, enS, pwmS} = syncBus.synced;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   lsfs_pkg::lsfs_state_e state, next_state;
   logic [TW-1:0] timer, next_timer;
   logic [TW-1:0] fbCnt, next_fbCnt;
   logic [TW-1:0] enLowCnt, next_enLowCnt;
   logic [TW-1:0] stepCnt, next_stepCnt;
   logic stepTick, next_stepTick;
   logic faultHold, next_faultHold;
   logic [lsfs_pkg::CODE_W-1:0] next_targetCode;
   logic [N-1:0] next_open, next_short, next_grounded, next_sink;
   logic next_boostEnable, next_powerLineEnable, next_faultPinOe;

   logic [N-1:0] live;
   logic anyLow, anyWindow, allHigh, supplyTrip, fbTrip, enLongLow, pulseClear;

   always_comb
   begin
      live = ~groundedChannel & ~openStringFault & ~shortedStringFault;
      anyLow = |(live & lowS);
      // Window: above low, not above mid, the regulated point
      anyWindow = |(live & ~lowS & ~midS);
      allHigh = (live != '0) && ((live & ~midS) == '0);
      supplyTrip = (uvS | ovS | swS) && (state == lsfs_pkg::ST_SOFT_START
                   || state == lsfs_pkg::ST_BOOST_START || state == lsfs_pkg::ST_NORMAL);
      fbTrip = (state == lsfs_pkg::ST_NORMAL) && fbS && (fbCnt >= TW'(FB_OVP_CYC)); // RULE_18
      enLongLow = !enS && (enLowCnt >= TW'(STANDBY_CYC));
      pulseClear = (state == lsfs_pkg::ST_NORMAL) && enS
                   && (enLowCnt >= TW'(lsfs_pkg::PULSE_MIN_CYC))
                   && (enLowCnt <= TW'(lsfs_pkg::PULSE_MAX_CYC)); // RULE_17
   end

   always_comb
   begin
      next_state = state;
      next_timer = timer + TW'(1);
      next_faultHold = faultHold;
      next_targetCode = targetCode;
      next_open = openStringFault;
      next_short = shortedStringFault;
      next_grounded = groundedChannel;
      next_fbCnt = (fbS && state == lsfs_pkg::ST_NORMAL)
                   ? ((fbCnt >= TW'(FB_OVP_CYC)) ? fbCnt : fbCnt + TW'(1)) : '0;
      next_enLowCnt = enS ? '0 : ((enLowCnt >= TW'(STANDBY_CYC)) ? enLowCnt : enLowCnt + TW'(1));
      next_stepTick = (stepCnt == TW'(STEP_CYC - 1));
      next_stepCnt = next_stepTick ? '0 : stepCnt + TW'(1);
      case (state)
         lsfs_pkg::ST_STANDBY:
         begin
            next_timer = '0;
            next_open = '0;
            next_short = '0;
            next_grounded = '0;
            next_faultHold = 1'b0;
            if (enS)
            begin
               next_state = lsfs_pkg::ST_SOFT_START;
            end
         end
         lsfs_pkg::ST_SOFT_START, lsfs_pkg::ST_BOOST_START:
         begin
            if (supplyTrip)
            begin
               next_state = lsfs_pkg::ST_RECOVERY; // RULE_07 RULE_09 RULE_11
               next_timer = '0;
               next_faultHold = 1'b1;
            end
            else if (enLongLow)
            begin
               next_state = lsfs_pkg::ST_STANDBY;
            end
            else if (state == lsfs_pkg::ST_SOFT_START && timer == TW'(SOFT_START_CYC - 1))
            begin
               next_state = lsfs_pkg::ST_BOOST_START;
               next_timer = '0;
               next_targetCode = lsfs_pkg::CODE_INIT; // RULE_04
            end
            else if (state == lsfs_pkg::ST_BOOST_START && timer == TW'(BOOST_START_CYC - 1))
            begin
               next_state = lsfs_pkg::ST_NORMAL;
               next_grounded = gndS; // RULE_05
               next_faultHold = 1'b0; // RULE_19
            end
         end
         lsfs_pkg::ST_NORMAL:
         begin
            if (supplyTrip || fbTrip)
            begin
               next_state = lsfs_pkg::ST_RECOVERY; // RULE_07 RULE_09 RULE_10 RULE_11
               next_timer = '0;
               next_faultHold = 1'b1;
            end
            else if (enLongLow)
            begin
               next_state = lsfs_pkg::ST_STANDBY;
            end
            else
            begin
               // A detection in the clearing cycle survives the clear
               next_open = openStringFault & ~{N{pulseClear}};
               next_short = shortedStringFault & ~{N{pulseClear}};
               if (stepTick && enS)
               begin
                  if (targetCode == lsfs_pkg::CODE_MAX)
                  begin
                     next_open = next_open | (live & lowS); // RULE_14 RULE_15
                  end
                  if (anyWindow)
                  begin
                     next_short = next_short | (live & highS); // RULE_12 RULE_16
                  end
                  if (anyLow)
                  begin
                     if (targetCode != lsfs_pkg::CODE_MAX)
                     begin
                        next_targetCode = targetCode + 8'h01; // RULE_01
                     end
                  end
                  else if (allHigh)
                  begin
                     if (targetCode != lsfs_pkg::CODE_MIN)
                     begin
                        next_targetCode = targetCode - 8'h01; // RULE_02
                     end
                  end
                  // Otherwise the lowest channel sits in the window: hold RULE_03
               end
            end
         end
         lsfs_pkg::ST_RECOVERY:
         begin
            // Trips are ignored here so the timer runs undisturbed RULE_21
            if (timer == TW'(RECOVERY_CYC - 1))
            begin
               next_state = lsfs_pkg::ST_SOFT_START; // RULE_08
               next_timer = '0;
               next_open = '0;
               next_short = '0;
            end
         end
         default:
         begin
            next_state = lsfs_pkg::ST_STANDBY;
            next_timer = '0;
         end
      endcase
      next_boostEnable = (next_state == lsfs_pkg::ST_BOOST_START)
                         || (next_state == lsfs_pkg::ST_NORMAL); // RULE_21
      next_powerLineEnable = (next_state == lsfs_pkg::ST_SOFT_START) || next_boostEnable;
      // Sinks follow the brightness PWM after the sync latency plus one output register
      next_sink = (next_state == lsfs_pkg::ST_NORMAL && enS && pwmS)
                  ? (~next_grounded & ~next_open & ~next_short) : '0; // RULE_06 RULE_15
      next_faultPinOe = next_faultHold || (next_open != '0) || (next_short != '0); // RULE_13
      if (srst)
      begin
         next_state = lsfs_pkg::ST_STANDBY;
         next_timer = '0;
         next_fbCnt = '0;
         next_enLowCnt = '0;
         next_stepCnt = '0;
         next_stepTick = 1'b0;
         next_faultHold = 1'b0;
         next_targetCode = lsfs_pkg::CODE_INIT;
         next_open = '0;
         next_short = '0;
         next_grounded = '0;
         next_sink = '0;
         next_boostEnable = 1'b0;
         next_powerLineEnable = 1'b0;
         next_faultPinOe = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      state <= next_state;
      timer <= next_timer;
      fbCnt <= next_fbCnt;
      enLowCnt <= next_enLowCnt;
      stepCnt <= next_stepCnt;
      stepTick <= next_stepTick;
      faultHold <= next_faultHold;
      targetCode <= next_targetCode;
      openStringFault <= next_open;
      shortedStringFault <= next_short;
      groundedChannel <= next_grounded;
      ledSinkChannel <= next_sink;
      boostEnable <= next_boostEnable;
      powerLineEnable <= next_powerLineEnable;
      faultPinOe <= next_faultPinOe;
      faultPinOut <= 1'b0;
      stateCode <= next_state;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   logic normTick;
   assign normTick = (state == lsfs_pkg::ST_NORMAL) && stepTick && enS && !supplyTrip
                     && !fbTrip && !enLongLow;

   AST_STEP_UP: assert property (normTick && anyLow && targetCode != lsfs_pkg::CODE_MAX
      |=> targetCode == $past(targetCode) + 8'h01) else $error("target did not rise"); // RULE_01
   AST_STEP_DOWN: assert property (normTick && !anyLow && allHigh
      && targetCode != lsfs_pkg::CODE_MIN |=> targetCode == $past(targetCode) - 8'h01)
      else $error("target did not fall"); // RULE_02
   AST_HOLD: assert property (normTick && !anyLow && !allHigh |=> $stable(targetCode))
      else $error("target moved while regulated"); // RULE_03
   AST_INIT: assert property (state == lsfs_pkg::ST_SOFT_START
      ##1 state == lsfs_pkg::ST_BOOST_START |-> targetCode == lsfs_pkg::CODE_INIT)
      else $error("target not at initial level"); // RULE_04
   AST_GROUNDED_OFF: assert property ((ledSinkChannel & groundedChannel) == '0)
      else $error("grounded sink driven"); // RULE_05
   AST_PWM_OFF: assert property (!pwmS |=> ledSinkChannel == '0)
      else $error("sink on with PWM low"); // RULE_06
   AST_SUPPLY_TRIP: assert property (supplyTrip |=> state == lsfs_pkg::ST_RECOVERY
      && faultPinOe && !boostEnable && !powerLineEnable && ledSinkChannel == '0)
      else $error("supply fault not handled"); // RULE_07
   AST_RECOVERY_EXIT: assert property (state == lsfs_pkg::ST_RECOVERY
      && timer == TW'(RECOVERY_CYC - 1) |=> state == lsfs_pkg::ST_SOFT_START)
      else $error("recovery did not end on time"); // RULE_08
   AST_RECOVERY_STAY: assert property (state == lsfs_pkg::ST_RECOVERY
      && timer < TW'(RECOVERY_CYC - 1) |=> state == lsfs_pkg::ST_RECOVERY
      && timer == $past(timer) + TW'(1) && !boostEnable)
      else $error("recovery cut short"); // RULE_21
   AST_FB_PERSIST: assert property (state == lsfs_pkg::ST_NORMAL && !fbS
      |=> fbCnt == '0) else $error("feedback count not reset"); // RULE_18
   AST_FB_TRIP: assert property (fbTrip |=> state == lsfs_pkg::ST_RECOVERY && faultPinOe)
      else $error("feedback overvoltage not handled"); // RULE_10
   AST_OPEN: assert property (normTick && targetCode == lsfs_pkg::CODE_MAX && anyLow
      |=> (openStringFault & $past(live & lowS)) == $past(live & lowS))
      else $error("open string not flagged"); // RULE_14
   AST_SHORT: assert property (normTick && anyWindow && (live & highS) != '0
      |=> (shortedStringFault & $past(live & highS)) == $past(live & highS))
      else $error("short string not flagged"); // RULE_16
   AST_LED_FAULT_PIN: assert property ((openStringFault | shortedStringFault) != '0
      |-> faultPinOe) else $error("LED fault not on pin"); // RULE_13
   AST_RELEASE: assert property (state == lsfs_pkg::ST_BOOST_START
      ##1 state == lsfs_pkg::ST_NORMAL |-> !faultHold) else $error("pin held after restart"); // RULE_19
endmodule // lsfs_supervisor
`default_nettype wire

// ==== testbench/lsfs_led_model.sv ====
// Behavioural LED strings and sink comparators facing the supervisor
`timescale 1ns/10ps
`default_nettype none
module lsfs_led_model
(
   input wire logic [lsfs_pkg::CODE_W-1:0] targetCode,
   input wire logic [lsfs_pkg::NUM_CH*lsfs_pkg::CODE_W-1:0] needCodes,
   input wire logic [lsfs_pkg::NUM_CH-1:0] groundMask,
   input wire logic [lsfs_pkg::NUM_CH-1:0] openMask,
   input wire logic [lsfs_pkg::NUM_CH-1:0] shortMask,
   output logic [lsfs_pkg::NUM_CH-1:0] chanBelowLow,
   output logic [lsfs_pkg::NUM_CH-1:0] chanAboveMid,
   output logic [lsfs_pkg::NUM_CH-1:0] chanAboveHigh
);
   // ----------------------------------------------------------------
   // Cathode comparators
   // ----------------------------------------------------------------
   // A string regulates while the target is its need code or one above
   always_comb
   begin
      for (int i = 0; i < lsfs_pkg::NUM_CH; i++)
      begin
         logic [8:0] need;
         need = {1'b0, needCodes[i*lsfs_pkg::CODE_W +: lsfs_pkg::CODE_W]};
         if (groundMask[i] || openMask[i])
         begin
            // A grounded or broken string pulls its cathode to zero
            chanBelowLow[i] = 1'b1;
            chanAboveMid[i] = 1'b0;
            chanAboveHigh[i] = 1'b0;
         end
         else if (shortMask[i])
         begin
            chanBelowLow[i] = 1'b0;
            chanAboveMid[i] = 1'b1;
            chanAboveHigh[i] = 1'b1;
         end
         else
         begin
            chanBelowLow[i] = {1'b0, targetCode} < need;
            chanAboveMid[i] = {1'b0, targetCode} > need + 9'h001;
            chanAboveHigh[i] = 1'b0;
         end
      end
   end
endmodule // lsfs_led_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the LED boost fault supervisor
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int unsigned REC_CYC = 200;
   localparam int unsigned FB_CYC = 100;
   localparam int LIMIT_CYC = 40000;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] tripIn = 3'h0;
   logic feedbackOverV = 1'b0;
   logic enableInput = 1'b0;
   logic pwmInput = 1'b1;
   logic [3:0] groundMask = 4'h8;
   logic [3:0] openMask = 4'h0;
   logic [3:0] shortMask = 4'h0;
   logic [31:0] needCodes = 32'h00E8E8F0;
   wire logic [3:0] chanBelowLow, chanAboveMid, chanAboveHigh, ledSinkChannel;
   wire logic [3:0] openStringFault, shortedStringFault, groundedChannel;
   wire logic [7:0] targetCode;
   wire logic [2:0] stateCode;
   wire logic boostEnable, powerLineEnable, faultPinOut, faultPinOe;
   int errTotal = 0;
   int samplesChecked = 0;
   int cycleCount = 0;
   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   // Short counts keep the run brief; the standby delay must exceed the clear pulse
   lsfs_supervisor #(.RECOVERY_CYC(REC_CYC), .SOFT_START_CYC(50), .BOOST_START_CYC(50),
      .FB_OVP_CYC(FB_CYC), .STANDBY_CYC(3000), .STEP_CYC(4)) DUT (
      .mclk(mclk), .srst(srst), .supplyUnderV(tripIn[0]), .supplyOverV(tripIn[1]),
      .feedbackOverV(feedbackOverV), .switchNodeOverV(tripIn[2]),
      .chanBelowLow(chanBelowLow), .chanAboveMid(chanAboveMid),
      .chanAboveHigh(chanAboveHigh), .chanGrounded(groundMask),
      .enableInput(enableInput), .pwmInput(pwmInput), .boostEnable(boostEnable),
      .powerLineEnable(powerLineEnable), .ledSinkChannel(ledSinkChannel),
      .targetCode(targetCode), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe),
      .openStringFault(openStringFault), .shortedStringFault(shortedStringFault),
      .groundedChannel(groundedChannel), .stateCode(stateCode));
   lsfs_led_model model (.targetCode(targetCode), .needCodes(needCodes),
      .groundMask(groundMask), .openMask(openMask), .shortMask(shortMask),
      .chanBelowLow(chanBelowLow), .chanAboveMid(chanAboveMid),
      .chanAboveHigh(chanAboveHigh));
   always #4 mclk = ~mclk;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic closeOut;
      $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycleCount++;
      if (cycleCount == LIMIT_CYC)
      begin
         errTotal++;
         $display("[ERR] %0t run exceeded its cycle limit", $time);
         closeOut;
      end
   end
   task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
      samplesChecked++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[ERR] %0t %s: got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_state(input logic [2:0] st, input int limit);
      int n;
      n = 0;
      while (stateCode !== st && n < limit)
      begin
         tick(1);
         n++;
      end
      expect_eq(stateCode, st, "state reached");
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_startup;
      expect_eq(stateCode, lsfs_pkg::ST_STANDBY, "standby after reset");
      expect_eq(targetCode, lsfs_pkg::CODE_INIT, "initial target");
      @(posedge mclk);
      enableInput <= 1'b1;
      wait_state(lsfs_pkg::ST_SOFT_START, 8);
      expect_eq(powerLineEnable, 1'b1, "power line in soft start");
      wait_state(lsfs_pkg::ST_BOOST_START, 60);
      expect_eq({boostEnable, targetCode}, {1'b1, lsfs_pkg::CODE_INIT}, "boost start");
      wait_state(lsfs_pkg::ST_NORMAL, 60);
      expect_eq(groundedChannel, 4'h8, "grounded sink found");
      expect_eq(faultPinOe, 1'b0, "fault pin released");
   endtask
   task automatic t_adaptive;
      // The grounded sink reads low forever; it must not drag the target up
      tick(200);
      expect_eq(targetCode, 8'hF0, "target rises to weakest string");
      expect_eq(openStringFault, 4'h0, "no open fault");
      @(posedge mclk);
      needCodes[7:0] <= 8'hD0;
      tick(200);
      expect_eq(targetCode, 8'hE9, "target falls until a string regulates");
   endtask
   task automatic t_pwm;
      // Half period of a 20 kHz brightness signal
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk);
         pwmInput <= k[0];
         tick(6);
         expect_eq(ledSinkChannel, k[0] ? 4'h7 : 4'h0, "sinks follow pwm");
         tick(3119);
      end
   endtask
   task automatic t_open_clear;
      @(posedge mclk);
      openMask <= 4'h2;
      tick(200);
      expect_eq(openStringFault, 4'h2, "open string flagged");
      expect_eq({stateCode, ledSinkChannel}, {3'h3, 4'h5}, "others keep running");
      expect_eq(faultPinOe, 1'b1, "fault pin for open");
      @(posedge mclk);
      openMask <= 4'h0;
      enableInput <= 1'b0;
      tick(500);
      expect_eq(ledSinkChannel, 4'h0, "sinks off in clear pulse");
      @(posedge mclk);
      enableInput <= 1'b1;
      tick(6);
      expect_eq({stateCode, openStringFault, faultPinOe}, {3'h3, 4'h0, 1'b0}, "cleared");
   endtask
   task automatic t_short;
      @(posedge mclk);
      shortMask <= 4'h4;
      tick(40);
      expect_eq(shortedStringFault, 4'h4, "short flagged");
      expect_eq({faultPinOe, ledSinkChannel}, {1'b1, 4'h3}, "short excluded");
      @(posedge mclk);
      shortMask <= 4'h0;
   endtask
   task automatic t_trip(input int i);
      int n;
      n = 0;
      @(posedge mclk);
      tripIn[i] <= 1'b1;
      tick(2);
      expect_eq(stateCode, lsfs_pkg::ST_NORMAL, "trip passes synchroniser first");
      wait_state(lsfs_pkg::ST_RECOVERY, 4);
      expect_eq({faultPinOut, faultPinOe, boostEnable, powerLineEnable, ledSinkChannel}, 8'h40,
         "shutdown on trip");
      while (n < 400)
      begin
         @(posedge mclk);
         if (n == 0 || n == 60)
            tripIn[i] <= 1'b0;
         if (n == 50)
            tripIn[i] <= 1'b1;
         #1;
         if (stateCode !== lsfs_pkg::ST_RECOVERY)
            break;
         n++;
         if (n == 100)
            expect_eq({boostEnable, powerLineEnable, ledSinkChannel}, 6'h00, "off");
      end
      expect_eq(n + 1 >= REC_CYC && n + 1 <= REC_CYC + 1, 1'b1, "recovery length");
      expect_eq(stateCode, lsfs_pkg::ST_SOFT_START, "restart");
      wait_state(lsfs_pkg::ST_NORMAL, 150);
      expect_eq({faultPinOe, shortedStringFault}, 5'h00, "fault pin released");
   endtask
   task automatic t_feedback;
      int n;
      n = 0;
      @(posedge mclk);
      feedbackOverV <= 1'b1;
      #1;
      while (stateCode === lsfs_pkg::ST_NORMAL && n < 300)
      begin
         tick(1);
         n++;
      end
      expect_eq(n > FB_CYC && n <= FB_CYC + 8, 1'b1, "feedback persistence");
      expect_eq({stateCode, faultPinOe}, {3'h4, 1'b1}, "feedback trip");
      // Still high through restart: only the normal state may count it
      wait_state(lsfs_pkg::ST_NORMAL, 400);
      @(posedge mclk);
      feedbackOverV <= 1'b0;
   endtask
   task automatic t_standby;
      // Enable held low past the standby delay is a shutdown, not a fault clear
      @(posedge mclk);
      enableInput <= 1'b0;
      wait_state(lsfs_pkg::ST_STANDBY, 3010);
      expect_eq({powerLineEnable, boostEnable, ledSinkChannel, faultPinOe}, 7'h00, "standby");
      @(posedge mclk);
      enableInput <= 1'b1;
      wait_state(lsfs_pkg::ST_NORMAL, 120);
      expect_eq(groundedChannel, 4'h8, "grounded sink found again");
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      tick(1);
      t_startup;
      t_adaptive;
      t_pwm;
      t_open_clear;
      t_short;
      for (int i = 0; i < 3; i++)
         t_trip(i);
      t_feedback;
      t_standby;
      closeOut;
   end
endmodule // testbench
`default_nettype wire
